// *** ddc_pkg.sv ***
// Package: register map, field positions and reset values of the bus-interface core.
// Assumes an APB slave with 32-bit data, one byte register per aligned word.
package ddc_pkg;
   // Printed offsets are not all multiples of four: they are register indices, byte address = 4 * index
   localparam logic [7:0] IDX_SLAVE_ADDRESS_SHORT   = 8'hea;
   localparam logic [7:0] IDX_BUS_CLOCK_CONTROL     = 8'heb;
   localparam logic [7:0] IDX_CONTROL_STATUS_FIRST  = 8'hec;
   localparam logic [7:0] IDX_CONTROL_STATUS_SECOND = 8'hed;
   localparam logic [7:0] IDX_SLAVE_ADDRESS_LONG    = 8'hee;
   localparam logic [7:0] IDX_TRANSMIT_PREBUFFER    = 8'hef;
   localparam logic [7:0] IDX_RECEIVE_PREBUFFER     = 8'hf0;
   localparam logic [7:0] IDX_SERIAL_SHIFT_REGISTER = 8'hf1;
   localparam logic [7:0] IDX_MODE_CONTROL_REGISTER = 8'he9;
   // bus_clock_control fields
   localparam int BCC_ACK_EN  = 7;
   localparam int BCC_SRC_SEL = 6;
   localparam int BCC_IRQ_EN  = 5;
   localparam int BCC_PEND    = 4;
   // control_status_first fields
   localparam int CSF_BUSY    = 5;
   localparam int CSF_ENABLE  = 4;
   localparam int CSF_ARBLOST = 3;
   localparam int CSF_FIELD   = 2;
   localparam int CSF_MATCH   = 1;
   localparam int CSF_LASTBIT = 0;
   // control_status_second fields
   localparam int CSS_STOP    = 2;
   localparam int CSS_TXFULL  = 1;
   localparam int CSS_RXFULL  = 0;
   // mode_control_register fields
   localparam int MCR_PREBUF  = 3;
   localparam int MCR_ADMATCH = 2;
   // Reset values
   localparam logic [7:0] RST_BUS_CLOCK_CONTROL = 8'h00;
   localparam logic [7:0] RST_CSF_CONTROL       = 8'h00;
   localparam logic       RST_PREBUF_EN         = 1'b1;
endpackage

// *** ddc_divider.sv ***
// Divider: one-cycle enable every (terminal+1) input enables.
// Assumes en_in pulses are one cycle wide on pclk.
`timescale 1ns/100ps
module ddc_divider #(
   parameter int WIDTH = 8
) (
   input  wire logic             pclk,      // System clock
   input  wire logic             presetn,   // Async reset, active low
   input  wire logic             en_in,     // Input rate enable
   input  wire logic [WIDTH-1:0] terminal,  // Divide ratio minus one
   output logic                  en_out     // Output rate enable
);
   logic [WIDTH-1:0] count_ff;
   initial begin
      if (WIDTH < 1) $error("ddc_divider: WIDTH must be positive");
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_ff <= '0;
         en_out   <= 1'b0;
      end else begin
         en_out <= 1'b0;
         if (en_in) begin
            if (count_ff >= terminal) begin
               count_ff <= '0;
               en_out   <= 1'b1;
            end else begin
               count_ff <= count_ff + 1'b1;
            end
         end
      end
   end
endmodule // ddc_divider

// *** ddc_iic_prebuffer_interface.sv ***
// Register-level core of the display-data-channel two-wire interface: registers, prescaler,
// pending flag, arbitration flag, shift register, address latches and pre-buffers.
// Assumes a protocol sequencer outside drives the event strobes and bit timing inputs.
//
// Contract
// - Interrupt goes to level three vector; request only while enable bit is one.
// - Pending flag clears on zero write; writing one has no effect.
// - Pending set on address match, arbitration loss, byte done, sync mode; zero if disabled.
// - Acknowledge driven only when acknowledge enable is one.
// - Source select: zero gives oscillator/10, one gives oscillator/256.
// - Serial clock is prescaler input divided by field plus one.
// - Lower four bits of first status register are read-only; upper four writable.
// - Master arbitration failure sets arbitration-failed bit.
// - Slave: changing upper control bits while busy and field zero sets arbitration bit.
// - Driving one but sampling zero on data line sets arbitration bit.
// - Second status has stop, transmit full, receive full; buffer flags read-only.
// - Shift out most significant bit first; shift received bits in serially.
// - Shift register writable when enabled and pre-buffer off; read always.
// - Short address latch four bits, writable only when disabled.
// - Long address latch seven bits, writable only when disabled.
// - Transmit pre-buffer writable only when enabled; read always.
// - Pre-buffer on, not full: on read match or acked byte, copy and interrupt.
// - Writing the transmit pre-buffer clears the transmit full flag.
// - Transmit full blocks the copy on address match.
// - Not acknowledged transmitted byte releases the data line.
// - Pre-buffer off and field one: hold clock low until shift write and pending clear; code releases on pending clear (or disable) alone.
// - Receive pre-buffer loads after data byte when empty; read clears full flag.
// - Pre-buffer enable set by reset or by writing one; zero selects plain mode.
// - Address-match bit set on match with short latch; cleared by start or stop.
`timescale 1ns/100ps
module ddc_iic_prebuffer_interface #(
   parameter int OSC_DIV_FAST = 10,   // First source divide
   parameter int OSC_DIV_SLOW = 256   // Second source divide
) (
   input  wire logic        pclk,            // APB clock, also oscillator
   input  wire logic        presetn,         // Async reset, active low
   input  wire logic        psel,            // APB select
   input  wire logic        penable,         // APB enable
   input  wire logic        pwrite,          // APB direction
   input  wire logic [11:0] paddr,           // APB byte address
   input  wire logic [31:0] pwdata,          // APB write data
   output logic      [31:0] prdata,          // APB read data
   output logic             pready,          // APB ready
   output logic             pslverr,         // APB error on unmapped address
   input  wire logic        ev_start,        // Start condition seen
   input  wire logic        ev_stop,         // Stop condition seen
   input  wire logic        ev_addr_done,    // Address byte received in shift register
   input  wire logic        ev_byte_done,    // Data byte transferred
   input  wire logic        ev_arb_lost,     // Master arbitration failed
   input  wire logic        ev_sync_mode,    // Sync-clocked transmit mode enabled after pre-buffer use
   input  wire logic        bit_shift,       // Shift strobe, one bit per pulse
   input  wire logic        bit_in,          // Sampled data line level
   input  wire logic        ack_slot,        // Ninth clock slot is in progress
   input  wire logic        ack_in,          // Sampled acknowledge from receiver
   output logic             serial_data_pin_o,  // Data line output level
   output logic             serial_data_pin_oe, // Data line pull-down enable
   output logic             serial_clock_pin_o, // Clock line output level
   output logic             serial_clock_pin_oe,// Clock line pull-down enable
   output logic             sclk_tick,       // Serial clock rate enable
   output logic             irq_level_three  // Interrupt to level three
);
   localparam logic [7:0] FAST_TC = 8'(OSC_DIV_FAST - 1);
   localparam logic [7:0] SLOW_TC = 8'(OSC_DIV_SLOW - 1);
   initial begin
      if (OSC_DIV_FAST < 1 || OSC_DIV_FAST > 256 || OSC_DIV_SLOW < 1 || OSC_DIV_SLOW > 256)
         $error("ddc_iic_prebuffer_interface: source divide out of range");
   end

   // ==========================================================
   // Register state
   logic [7:0] bcc_ff;          // ack_en, src, irq_en, pend, prescale
   logic [3:0] csf_ctl_ff;      // mode bits 7..4
   logic       arb_ff;
   logic       field_ff;
   logic       match_ff;
   logic       lastbit_ff;
   logic       stop_ff;
   logic       txfull_ff;
   logic       rxfull_ff;
   logic       prebuf_en_ff;
   logic       admatch_ff;
   logic [3:0] addr_short_ff;
   logic [6:0] addr_long_ff;
   logic [7:0] txbuf_ff;
   logic [7:0] rxbuf_ff;
   logic [7:0] shift_ff;
   logic       hold_ff;
   logic       drive_one_ff;

   // ==========================================================
   // APB decode
   localparam logic [7:0] IDX_LO = ddc_pkg::IDX_MODE_CONTROL_REGISTER;
   logic       acc;
   logic       wr;
   logic       rd;
   logic [9:0] idx;
   logic       mapped;
   assign acc = psel && penable;
   assign wr  = acc && pwrite;
   assign rd  = acc && !pwrite;
   assign idx = paddr[11:2];
   assign mapped = (paddr[1:0] == 2'b00) && (idx[9:8] == 2'b00) &&
                   ((idx[7:0] >= IDX_LO) && (idx[7:0] <= ddc_pkg::IDX_SERIAL_SHIFT_REGISTER));
   logic [7:0] wd;
   assign wd = pwdata[7:0];
   function automatic logic hit(input logic [7:0] r);
      hit = mapped && (idx[7:0] == r);
   endfunction

   logic enabled;
   assign enabled = csf_ctl_ff[ddc_pkg::CSF_ENABLE-4];
   logic is_master;
   assign is_master = csf_ctl_ff[2];    // bit 6
   logic is_tx;
   assign is_tx = csf_ctl_ff[3];        // bit 7

   // ==========================================================
   // Prescaler
   logic src_tick;
   ddc_divider #(.WIDTH(8)) u_src_div (
      .pclk     (pclk),
      .presetn  (presetn),
      .en_in    (1'b1),
      .terminal (bcc_ff[ddc_pkg::BCC_SRC_SEL] ? SLOW_TC : FAST_TC),
      .en_out   (src_tick)
   );
   logic [3:0] pre_cnt_ff;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_cnt_ff <= 4'h0;
         sclk_tick  <= 1'b0;
      end else begin
         sclk_tick <= 1'b0;
         if (src_tick) begin
            if (pre_cnt_ff >= bcc_ff[3:0]) begin
               pre_cnt_ff <= 4'h0;
               sclk_tick  <= 1'b1;
            end else begin
               pre_cnt_ff <= pre_cnt_ff + 4'h1;
            end
         end
      end
   end

   // ==========================================================
   // Pre-buffer transfer conditions
   logic read_match;
   logic addr_ok;
   assign addr_ok = (shift_ff[7:1] == addr_long_ff) || (shift_ff[7:4] == addr_short_ff);
   assign read_match = ev_addr_done && addr_ok && shift_ff[0];
   logic ack_done;
   assign ack_done = ev_byte_done && is_tx && !ack_in;
   logic tx_copy;
   assign tx_copy = prebuf_en_ff && !txfull_ff && (read_match || ack_done);
   logic rx_load;
   assign rx_load = prebuf_en_ff && ev_byte_done && !is_tx && field_ff && !rxfull_ff;

   // ==========================================================
   // Clock control and pending flag
   logic set_pend;
   assign set_pend = (ev_addr_done && addr_ok) || (ev_arb_lost && is_master) ||
                     ev_byte_done || ev_sync_mode || tx_copy;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bcc_ff <= ddc_pkg::RST_BUS_CLOCK_CONTROL;
      end else begin
         if (wr && hit(ddc_pkg::IDX_BUS_CLOCK_CONTROL)) begin
            bcc_ff[7:5] <= wd[7:5];
            bcc_ff[3:0] <= wd[3:0];
         end
         if (!enabled) begin
            bcc_ff[ddc_pkg::BCC_PEND] <= 1'b0;
         end else if (set_pend) begin
            bcc_ff[ddc_pkg::BCC_PEND] <= 1'b1;
         end else if (wr && hit(ddc_pkg::IDX_BUS_CLOCK_CONTROL) && !wd[ddc_pkg::BCC_PEND]) begin
            bcc_ff[ddc_pkg::BCC_PEND] <= 1'b0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_level_three <= 1'b0;
      end else begin
         irq_level_three <= bcc_ff[ddc_pkg::BCC_PEND] && bcc_ff[ddc_pkg::BCC_IRQ_EN];
      end
   end

   // ==========================================================
   // Control/status first
   logic csf_wr;
   assign csf_wr = wr && hit(ddc_pkg::IDX_CONTROL_STATUS_FIRST);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         csf_ctl_ff <= ddc_pkg::RST_CSF_CONTROL[7:4];
         arb_ff     <= 1'b0;
      end else begin
         if (csf_wr) begin
            csf_ctl_ff <= wd[7:4];
         end
         if ((ev_arb_lost && is_master) ||
             (csf_wr && !is_master && (wd[7:4] != csf_ctl_ff) &&
              csf_ctl_ff[ddc_pkg::CSF_BUSY-4] && !field_ff) ||
             (drive_one_ff && bit_shift && !bit_in)) begin
            arb_ff <= 1'b1;
         end else if (ev_start) begin
            arb_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         field_ff   <= 1'b0;
         match_ff   <= 1'b0;
         lastbit_ff <= 1'b0;
         admatch_ff <= 1'b0;
      end else begin
         if (ev_start || ev_stop) begin
            field_ff   <= 1'b0;
            match_ff   <= 1'b0;
            admatch_ff <= 1'b0;
         end else if (ev_addr_done) begin
            field_ff   <= 1'b1;
            match_ff   <= addr_ok;
            admatch_ff <= (shift_ff[7:4] == addr_short_ff);
         end
         if (ack_slot) begin
            lastbit_ff <= ack_in;
         end
      end
   end

   // ==========================================================
   // Control/status second and mode control
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stop_ff      <= 1'b0;
         prebuf_en_ff <= ddc_pkg::RST_PREBUF_EN;
      end else begin
         if (ev_stop) begin
            stop_ff <= 1'b1;
         end else if (wr && hit(ddc_pkg::IDX_CONTROL_STATUS_SECOND) && !wd[ddc_pkg::CSS_STOP]) begin
            stop_ff <= 1'b0;
         end
         if (wr && hit(ddc_pkg::IDX_MODE_CONTROL_REGISTER)) begin
            prebuf_en_ff <= wd[ddc_pkg::MCR_PREBUF];
         end
      end
   end

   // ==========================================================
   // Address latches
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr_short_ff <= 4'h0;
         addr_long_ff  <= 7'h00;
      end else if (!enabled && wr) begin
         if (hit(ddc_pkg::IDX_SLAVE_ADDRESS_SHORT)) begin
            addr_short_ff <= wd[7:4];
         end
         if (hit(ddc_pkg::IDX_SLAVE_ADDRESS_LONG)) begin
            addr_long_ff <= wd[7:1];
         end
      end
   end

   // ==========================================================
   // Pre-buffers; a copy in the same cycle as a write sets full again, so the set wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         txbuf_ff  <= 8'h00;
         txfull_ff <= 1'b0;
         rxbuf_ff  <= 8'h00;
         rxfull_ff <= 1'b0;
      end else begin
         if (enabled && wr && hit(ddc_pkg::IDX_TRANSMIT_PREBUFFER)) begin
            txbuf_ff <= wd;
         end
         if (tx_copy || (read_match && txfull_ff)) begin
            txfull_ff <= 1'b1;
         end else if (enabled && wr && hit(ddc_pkg::IDX_TRANSMIT_PREBUFFER)) begin
            txfull_ff <= 1'b0;
         end
         if (rx_load) begin
            rxbuf_ff  <= shift_ff;
            rxfull_ff <= 1'b1;
         end else if (rd && hit(ddc_pkg::IDX_RECEIVE_PREBUFFER)) begin
            rxfull_ff <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Shift register and line drive
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shift_ff     <= 8'h00;
         drive_one_ff <= 1'b0;
      end else begin
         if (tx_copy) begin
            shift_ff <= txbuf_ff;
         end else if (enabled && !prebuf_en_ff && wr && hit(ddc_pkg::IDX_SERIAL_SHIFT_REGISTER)) begin
            shift_ff <= wd;
         end else if (bit_shift) begin
            shift_ff <= {shift_ff[6:0], bit_in};
         end
         drive_one_ff <= is_tx && shift_ff[7] && !ack_slot;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_ff <= 1'b0;
      end else begin
         if (!prebuf_en_ff && field_ff && set_pend) begin
            hold_ff <= 1'b1;
         end else if (!bcc_ff[ddc_pkg::BCC_PEND] || !enabled) begin
            hold_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         serial_data_pin_o   <= 1'b0;
         serial_data_pin_oe  <= 1'b0;
         serial_clock_pin_o  <= 1'b0;
         serial_clock_pin_oe <= 1'b0;
      end else begin
         serial_clock_pin_oe <= hold_ff;
         if (ack_slot) begin
            serial_data_pin_oe <= enabled && !is_tx && bcc_ff[ddc_pkg::BCC_ACK_EN];
         end else if (is_tx && lastbit_ff) begin
            serial_data_pin_oe <= 1'b0;
         end else begin
            serial_data_pin_oe <= enabled && is_tx && !shift_ff[7];
         end
      end
   end

   // ==========================================================
   // Read mux and APB answer
   logic [7:0] rmux;
   always_comb begin
      rmux = 8'h00;
      unique case (1'b1)
         hit(ddc_pkg::IDX_MODE_CONTROL_REGISTER): rmux = {4'h0, prebuf_en_ff, admatch_ff, 2'b00};
         hit(ddc_pkg::IDX_SLAVE_ADDRESS_SHORT):   rmux = {addr_short_ff, 4'h0};
         hit(ddc_pkg::IDX_BUS_CLOCK_CONTROL):     rmux = bcc_ff;
         hit(ddc_pkg::IDX_CONTROL_STATUS_FIRST):  rmux = {csf_ctl_ff, arb_ff, field_ff, match_ff, lastbit_ff};
         hit(ddc_pkg::IDX_CONTROL_STATUS_SECOND): rmux = {5'h00, stop_ff, txfull_ff, rxfull_ff};
         hit(ddc_pkg::IDX_SLAVE_ADDRESS_LONG):    rmux = {addr_long_ff, 1'b0};
         hit(ddc_pkg::IDX_TRANSMIT_PREBUFFER):    rmux = txbuf_ff;
         hit(ddc_pkg::IDX_RECEIVE_PREBUFFER):     rmux = rxbuf_ff;
         hit(ddc_pkg::IDX_SERIAL_SHIFT_REGISTER): rmux = shift_ff;
         default:                                 rmux = 8'h00;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !mapped;
         prdata  <= {24'h00_0000, rmux};
      end
   end
endmodule // ddc_iic_prebuffer_interface

// *** ddc_iic_properties.sv ***
// Checker: port-level properties of the bus-interface core.
// Assumes it is bound to the core; one clock domain, pclk.
`timescale 1ns/100ps
module ddc_iic_properties #(
   parameter int OSC_DIV_FAST = 10  // First source divide
) (
   input wire logic        pclk,               // Clock
   input wire logic        presetn,            // Reset, active low
   input wire logic        psel,               // APB select
   input wire logic        penable,            // APB enable
   input wire logic        pwrite,             // APB direction
   input wire logic [11:0] paddr,              // APB address
   input wire logic [31:0] prdata,             // APB read data
   input wire logic        pready,             // APB ready
   input wire logic        pslverr,            // APB error
   input wire logic        serial_data_pin_o,  // Data line level
   input wire logic        serial_clock_pin_o, // Clock line level
   input wire logic        sclk_tick,          // Serial rate enable
   input wire logic        irq_level_three     // Interrupt
);
   // ====================
   // Cycles since the last rate tick, saturating
   logic [15:0] gap_ff;
   logic [15:0] nxt_gap;
   assign nxt_gap = sclk_tick ? 16'h0000 : (&gap_ff ? gap_ff : gap_ff + 16'h0001);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         gap_ff <= 16'hffff;
      else
         gap_ff <= nxt_gap;
   end
   // ====================
   // Properties
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence setup_s;
      psel && !penable;
   endsequence
   sequence clock_read_s;
      pready && psel && penable && !pwrite && paddr == 12'h3ac;
   endsequence
   ready_one_cycle_a: assert property (setup_s |=> pready)
      else $error("access phase not answered in one cycle");
   ready_in_access_a: assert property (pready |-> psel && penable)
      else $error("ready outside an access phase");
   err_unaligned_a: assert property (pready && paddr[1:0] != 2'b00 |-> pslverr)
      else $error("unaligned access not refused");
   err_with_ready_a: assert property (pslverr |-> pready)
      else $error("error flag without ready");
   read_upper_zero_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h000000)
      else $error("read data upper bits not zero");
   irq_masked_a: assert property (clock_read_s ##0 !prdata[5] |=> !irq_level_three)
      else $error("interrupt raised while disabled");
   irq_follows_pend_a: assert property (clock_read_s ##0 (prdata[5] && prdata[4]) |=> irq_level_three)
      else $error("interrupt missing with pending and enable");
   pins_open_drain_a: assert property (!serial_data_pin_o && !serial_clock_pin_o)
      else $error("line output level not low");
   tick_spacing_a: assert property (sclk_tick |-> gap_ff >= 16'(OSC_DIV_FAST - 1))
      else $error("serial rate ticks too close");
endmodule // ddc_iic_properties

bind ddc_iic_prebuffer_interface ddc_iic_properties #(
   .OSC_DIV_FAST(OSC_DIV_FAST)
) u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
   .serial_data_pin_o, .serial_clock_pin_o, .sclk_tick, .irq_level_three);

// *** ddc_bus_partner.sv ***
// Partner: the line sequencer, driving event strobes and serial bits.
// Assumes one pclk domain; its tasks are called by the bench.
`timescale 1ns/100ps
module ddc_bus_partner (
   input  wire logic pclk,         // Clock
   output logic      ev_start,     // Start seen
   output logic      ev_stop,      // Stop seen
   output logic      ev_addr_done, // Address byte in
   output logic      ev_byte_done, // Data byte done
   output logic      ev_arb_lost,  // Arbitration lost
   output logic      ev_sync_mode, // Sync mode entered
   output logic      bit_shift,    // Bit strobe
   output logic      bit_in,       // Sampled data level
   output logic      ack_slot,     // Ninth slot
   output logic      ack_in        // Receiver answer
);
   logic [5:0] ev_ff = 6'h00;
   assign {ev_sync_mode, ev_arb_lost, ev_byte_done, ev_addr_done, ev_stop, ev_start} = ev_ff;
   initial {bit_shift, bit_in, ack_slot, ack_in} = 4'h5;
   task pulse(input int k);
      @(posedge pclk);
      ev_ff[k] <= 1'b1;
      @(posedge pclk);
      ev_ff <= 6'h00;
   endtask
   // Level flips between strobes so a late sample cannot pass
   task send_byte(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         @(posedge pclk);
         bit_in    <= b[i];
         bit_shift <= 1'b1;
         @(posedge pclk);
         bit_in    <= ~b[i];
         bit_shift <= 1'b0;
      end
   endtask
endmodule // ddc_bus_partner

// *** test_ddc_iic_prebuffer_interface.sv ***
// Testbench: registers over APB, events from the partner, serial rate.
// Assumes core, package, partner and checker compiled alongside.
`timescale 1ns/100ps
module test_ddc_iic_prebuffer_interface;
   localparam int FAST = 10;
   localparam int SLOW = 256;
   localparam logic [7:0] BCC = ddc_pkg::IDX_BUS_CLOCK_CONTROL;
   localparam logic [7:0] CSF = ddc_pkg::IDX_CONTROL_STATUS_FIRST;
   localparam logic [7:0] SAS = ddc_pkg::IDX_SLAVE_ADDRESS_SHORT;
   localparam logic [7:0] SAL = ddc_pkg::IDX_SLAVE_ADDRESS_LONG;
   localparam logic [7:0] TXB = ddc_pkg::IDX_TRANSMIT_PREBUFFER;
   localparam logic [7:0] SSR = ddc_pkg::IDX_SERIAL_SHIFT_REGISTER;
   localparam logic [7:0] MCR = ddc_pkg::IDX_MODE_CONTROL_REGISTER;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic        ev_start, ev_stop, ev_addr_done, ev_byte_done, ev_arb_lost, ev_sync_mode;
   logic        bit_shift, bit_in, ack_slot, ack_in, sclk_tick, irq_level_three;
   logic [16:0] exp_q[$];
   logic [16:0] e;
   int          num_errors;
   int          samples_checked;
   ddc_iic_prebuffer_interface #(.OSC_DIV_FAST(FAST), .OSC_DIV_SLOW(SLOW)) u_dut (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .ev_start, .ev_stop, .ev_addr_done, .ev_byte_done, .ev_arb_lost, .ev_sync_mode,
      .bit_shift, .bit_in, .ack_slot, .ack_in, .serial_data_pin_o(), .serial_data_pin_oe(),
      .serial_clock_pin_o(), .serial_clock_pin_oe(), .sclk_tick, .irq_level_three);
   ddc_bus_partner u_far (.pclk, .ev_start, .ev_stop, .ev_addr_done, .ev_byte_done,
      .ev_arb_lost, .ev_sync_mode, .bit_shift, .bit_in, .ack_slot, .ack_in);
   // ====================
   // Tasks
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic results;
      $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Idle cycle between transfers keeps each signal to one assignment per step
   task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do @(posedge pclk); while (pready !== 1'b1 && n++ < 20);
      check("pready", 16'(pready), 16'h0001);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      xfer(1'b1, {2'b00, idx, 2'b00}, d);
   endtask
   task automatic rd(input logic [7:0] idx, v, m, input logic err = 1'b0, input logic [1:0] lo = 2'b00);
      exp_q.push_back({err, m, v & m});
      xfer(1'b0, {2'b00, idx, lo}, 8'h00);
   endtask
   task automatic measure(input logic src, input logic [3:0] p);
      int n;
      wr(BCC, {1'b0, src, 2'b00, p});
      repeat (3) begin
         n = 1;
         do @(negedge pclk); while (sclk_tick !== 1'b1 && n++ < 5000);
      end
      check("tick period", 16'(n), 16'((src ? SLOW : FAST) * (p + 1)));
   endtask
   task automatic irq_is(input logic v);
      @(negedge pclk);
      check("irq", 16'(irq_level_three), 16'(v));
   endtask
   // ====================
   // Read monitor
   always @(posedge pclk) begin
      if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
         e = exp_q.pop_front();
         check($sformatf("read %h", paddr), {7'h00, pslverr, prdata[7:0] & e[15:8]}, {7'h00, e[16], e[7:0]});
      end
   end
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   initial begin
      #400000;
      check("watchdog", 16'h0001, 16'h0000);
      results;
   end
   // ====================
   // Main sequence
   initial begin : main
      logic [7:0] r;
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      num_errors = 0;
      samples_checked = 0;
      void'($urandom(12128));
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      rd(MCR, 8'h08, 8'h0c);
      rd(BCC, 8'h00, 8'hff);
      rd(CSF, 8'h00, 8'hff);
      rd(8'h00, 8'h00, 8'h00, 1'b1);
      rd(BCC, 8'h00, 8'h00, 1'b1, 2'b01);
      wr(SAS, 8'hb0);
      wr(SAL, 8'h6e);
      wr(TXB, 8'h3c);
      rd(TXB, 8'h00, 8'hff);
      wr(CSF, 8'h1f);
      wr(SAS, 8'h50);
      wr(SAL, 8'h12);
      rd(SAS, 8'hb0, 8'hf0);
      rd(SAL, 8'h6e, 8'hfe);
      rd(CSF, 8'h10, 8'hff);
      r = 8'($urandom);
      wr(TXB, r);
      rd(TXB, r, 8'hff);
      u_far.send_byte(8'hb1);
      u_far.pulse(2);
      rd(MCR, 8'h0c, 8'h0c);
      wr(SSR, 8'ha5);
      rd(SSR, r, 8'hff);
      wr(MCR, 8'h00);
      wr(SSR, 8'ha5);
      rd(SSR, 8'ha5, 8'hff);
      r = 8'($urandom);
      u_far.send_byte(r);
      rd(SSR, r, 8'hff);
      wr(MCR, 8'h08);
      rd(MCR, 8'h08, 8'h08);
      wr(CSF, 8'h50);
      wr(BCC, 8'h20);
      for (int k = 3; k < 6; k++) begin
         u_far.pulse(k);
         rd(BCC, 8'h30, 8'h30);
         irq_is(1'b1);
         wr(BCC, 8'h30);
         rd(BCC, 8'h10, 8'h10);
         wr(BCC, 8'h20);
         rd(BCC, 8'h20, 8'h30);
         irq_is(1'b0);
      end
      rd(CSF, 8'h08, 8'h08);
      wr(BCC, 8'h00);
      u_far.pulse(3);
      rd(BCC, 8'h10, 8'h30);
      irq_is(1'b0);
      wr(BCC, 8'h00);
      u_far.pulse(0);
      rd(CSF, 8'h00, 8'h0e);
      wr(CSF, 8'h30);
      wr(CSF, 8'hb0);
      rd(CSF, 8'h08, 8'h08);
      wr(CSF, 8'h00);
      u_far.pulse(3);
      rd(BCC, 8'h00, 8'h10);
      wr(CSF, 8'h10);
      measure(1'b0, 4'hf);
      measure(1'b1, 4'h0);
      measure(1'b0, 4'($urandom));
      measure(1'b1, 4'($urandom));
      check("reads left", 16'(exp_q.size()), 16'h0000);
      results;
   end
endmodule // test_ddc_iic_prebuffer_interface
